// file: verilog/ioch_pkg.sv
package ioch_pkg;

  // register map
  localparam logic [7:0]  IOCH_CFG_OFFSET   = 8'h54;
  localparam logic [31:0] IOCH_CFG_RESET    = 32'h0000_0000;

  // field positions of interrupt_pin_config
  localparam int          IOCH_INTERVAL_LSB = 24;
  localparam int          IOCH_INTERVAL_W   = 8;
  localparam int          IOCH_RESTART_BIT  = 14;
  localparam int          IOCH_ACTIVE_BIT   = 13;
  localparam int          IOCH_IRQ_INT_BIT  = 12;
  localparam int          IOCH_EN_BIT       = 8;
  localparam int          IOCH_POL_BIT      = 4;
  localparam int          IOCH_TYPE_BIT     = 0;

  // reset values of the writable fields
  localparam logic [7:0]  IOCH_INTERVAL_RST = IOCH_CFG_RESET[31:24];
  localparam logic        IOCH_EN_RST       = IOCH_CFG_RESET[8];
  localparam logic        IOCH_POL_RST      = IOCH_CFG_RESET[4];
  localparam logic        IOCH_TYPE_RST     = IOCH_CFG_RESET[0];

  // buffer type encodings
  localparam logic        IOCH_OPEN_DRAIN   = 1'b0;
  localparam logic        IOCH_PUSH_PULL    = 1'b1;

  // timing: one hold-off step of 10 us at a 20 ns clock
  localparam int          IOCH_STEP_NS      = 10000;
  localparam int          IOCH_CLK_NS       = 20;
  localparam int          IOCH_STEP_CYCLES  = IOCH_STEP_NS / IOCH_CLK_NS;
  localparam int          IOCH_PRE_W        = $clog2(IOCH_STEP_CYCLES);

endpackage : ioch_pkg

// file: verilog/ioch_hold_if.sv
`timescale 1ns/1ps
interface ioch_hold_if;
  import ioch_pkg::*;

  logic                       start;
  logic                       stop;
  logic [IOCH_INTERVAL_W-1:0] len;
  logic                       active;

  modport ctl (output start, output stop, output len, input active);
  modport tmr (input start, input stop, input len, output active);
endinterface : ioch_hold_if

// file: verilog/ioch_holdoff_timer.sv
`timescale 1ns/1ps
module ioch_holdoff_timer
  import ioch_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  ioch_hold_if.tmr  hold
);

  typedef struct packed {
    logic                       active;
    logic [IOCH_INTERVAL_W-1:0] steps;
    logic [IOCH_PRE_W-1:0]      pre;
  } ioch_tmr_st_t;

  localparam logic [IOCH_PRE_W-1:0] PRE_LAST = IOCH_PRE_W'(IOCH_STEP_CYCLES - 1);

  ioch_tmr_st_t r;
  ioch_tmr_st_t n;

  always_comb begin
    n = r;
    if (hold.stop) begin
      n.active = 1'b0;
      n.steps  = '0;
      n.pre    = '0;
    end else if (hold.start) begin
      // length is sampled here, so a new value only affects later intervals
      n.active = (hold.len != '0);
      n.steps  = hold.len;
      n.pre    = '0;
    end else if (r.active) begin
      if (r.pre == PRE_LAST) begin
        n.pre   = '0;
        n.steps = r.steps - 8'h01;
        if (r.steps == 8'h01) begin
          n.active = 1'b0;
        end
      end else begin
        n.pre = r.pre + IOCH_PRE_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign hold.active = r.active;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  tick_bound_a: assert property (r.pre <= PRE_LAST)
    else $error("prescaler ran past one step");
  step_count_a: assert property (r.active && !hold.stop && !hold.start
                                 && r.pre == PRE_LAST |=> r.steps == $past(r.steps) - 8'h01)
    else $error("step counter did not advance on tick");
  load_len_a: assert property (hold.start && !hold.stop
                               |=> r.steps == $past(hold.len) && r.pre == '0)
    else $error("interval length not loaded at start");
  zero_stop_a: assert property (hold.stop |=> !r.active && r.steps == '0)
    else $error("stop did not clear interval");

endmodule : ioch_holdoff_timer

// file: verilog/ioch_top.sv
`timescale 1ns/1ps
// What this block does
// - bits 31:24 hold the hold-off length, in ten-microsecond steps
// - writing zero there stops the interval, clears counter, releases held interrupt
// - a new non-zero length applies to intervals starting after the write
// - the power event interrupt is never held off
// - writing one to bit 14 restarts the interval from zero, unless the same write sets the length to zero
// - bit 13 shows a running interval, during which the pin stays quiet except for a power event
// - bit 12 shows the combined enabled-source request
// - bit 12 ignores the output enable and the hold-off setting
// - bit 8 low keeps the pin deasserted, status bits untouched
// - bit 4 picks active-low or active-high in push-pull mode
// - bit 0 picks open-drain (always active low) or push-pull
module ioch_top
  import ioch_pkg::*;
#(
  parameter int N_SRC = 32
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  output logic      [31:0]      reg_rdata,
  input  wire logic [N_SRC-1:0] source_status,
  input  wire logic [N_SRC-1:0] source_enable,
  input  wire logic             power_event,
  output logic                  irq_pin_o,
  output logic                  irq_pin_oe
);

  typedef struct packed {
    logic [IOCH_INTERVAL_W-1:0] interval;
    logic                       irq_en;
    logic                       pol;
    logic                       buf_type;
    logic                       asserted;
    logic                       pin_o;
    logic                       pin_oe;
    logic [31:0]                rdata;
  } ioch_state_t;

  function automatic logic ioch_hit(input logic [7:0] addr);
    return addr == IOCH_CFG_OFFSET;
  endfunction : ioch_hit

  // one decoder for the length field, shared by the write path and the checks
  function automatic logic [IOCH_INTERVAL_W-1:0] ioch_len(input logic [31:0] word);
    return word[IOCH_INTERVAL_LSB +: IOCH_INTERVAL_W];
  endfunction : ioch_len

  ioch_state_t r;
  ioch_state_t n;
  ioch_hold_if hold ();

  logic        cfg_wr;
  logic        cfg_rd;
  logic        irq_int;
  logic        want;
  logic [31:0] cfg_word;

  ioch_holdoff_timer u_timer (
    .clock (clock),
    .srst  (srst),
    .hold  (hold.tmr)
  );

  always_comb begin
    cfg_wr  = reg_wr && ioch_hit(reg_addr);
    cfg_rd  = reg_rd && ioch_hit(reg_addr);
    // combined request sees neither the enable nor the hold-off
    irq_int = |(source_status & source_enable);

    cfg_word = '0;
    cfg_word[IOCH_INTERVAL_LSB +: IOCH_INTERVAL_W] = r.interval;
    cfg_word[IOCH_ACTIVE_BIT]  = hold.active;
    cfg_word[IOCH_IRQ_INT_BIT] = irq_int;
    cfg_word[IOCH_EN_BIT]      = r.irq_en;
    cfg_word[IOCH_POL_BIT]     = r.pol;
    cfg_word[IOCH_TYPE_BIT]    = r.buf_type;

    n = r;
    if (cfg_wr) begin
      n.interval = ioch_len(reg_wdata);
      n.irq_en   = reg_wdata[IOCH_EN_BIT];
      n.pol      = reg_wdata[IOCH_POL_BIT];
      n.buf_type = reg_wdata[IOCH_TYPE_BIT];
    end

    // power event bypasses the hold-off; enable gates only the pin
    want = r.irq_en && (power_event || (irq_int && !hold.active));
    n.asserted = want;

    // start a hold-off on each falling pin, unless one is already running;
    // restart bit ignores that guard and reloads, unless the write's length is zero (stop wins)
    hold.stop  = cfg_wr && (ioch_len(reg_wdata) == '0);
    hold.start = (r.asserted && !want && !hold.active)
                 || (cfg_wr && reg_wdata[IOCH_RESTART_BIT]);
    hold.len   = cfg_wr ? ioch_len(reg_wdata) : r.interval;

    if (n.buf_type == IOCH_PUSH_PULL) begin
      n.pin_oe = 1'b1;
      n.pin_o  = n.pol ? want : !want;
    end else begin
      // wired-or: drive low only when asserted, polarity ignored
      n.pin_oe = want;
      n.pin_o  = 1'b0;
    end

    // restart bit is self-clearing and always reads zero
    n.rdata = cfg_rd ? cfg_word : '0;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r          <= '0;
      r.interval <= IOCH_INTERVAL_RST;
      r.irq_en   <= IOCH_EN_RST;
      r.pol      <= IOCH_POL_RST;
      r.buf_type <= IOCH_TYPE_RST;
      // open-drain at reset: pin released
      r.pin_oe   <= 1'b0;
      r.pin_o    <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata  = r.rdata;
  assign irq_pin_o  = r.pin_o;
  assign irq_pin_oe = r.pin_oe;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // delivery and hold-off
  pin_disabled_a: assert property (!r.irq_en && !cfg_wr |=> !r.asserted)
    else $error("pin asserted while output disabled");
  holdoff_block_a: assert property (hold.active && !power_event |=> !r.asserted)
    else $error("interrupt delivered during hold-off");
  deliver_a: assert property (r.irq_en && irq_int && !hold.active |=> r.asserted)
    else $error("pending interrupt not delivered");
  power_bypass_a: assert property (r.irq_en && power_event |=> r.asserted)
    else $error("power event held off");
  pe_hold_a: assert property (hold.active && power_event && r.irq_en |=> r.asserted)
    else $error("power event blocked by running interval");
  power_no_en_a: assert property (power_event && !r.irq_en |=> !r.asserted)
    else $error("power event passed a disabled output");
  zero_release_a: assert property (cfg_wr && reg_wdata[31:24] == 8'h00
                                   |=> !hold.active)
    else $error("zero interval did not end hold-off");
  stop_wins_a: assert property (cfg_wr && ioch_len(reg_wdata) == 8'h00
                                && reg_wdata[IOCH_RESTART_BIT] |=> !hold.active)
    else $error("restart beat a zero interval");
  idle_zero_a: assert property (r.interval == 8'h00 |-> !hold.active)
    else $error("hold-off running with zero interval");
  release_a: assert property (cfg_wr && ioch_len(reg_wdata) == 8'h00
                              && reg_wdata[IOCH_EN_BIT] ##1 irq_int |=> r.asserted)
    else $error("held interrupt not issued after zero write");
  restart_a: assert property (cfg_wr && reg_wdata[14] && reg_wdata[31:24] != 8'h00
                              |=> hold.active)
    else $error("restart did not begin an interval");
  // the fall is seen while the pin register still shows it asserted
  fall_start_a: assert property (r.asserted && !want && !hold.active && !cfg_wr
                                 && r.interval != 8'h00 |=> hold.active)
    else $error("deassertion did not start an interval");
  expire_a: assert property ($fell(hold.active) && r.irq_en && irq_int |=> r.asserted)
    else $error("interrupt not delivered after hold-off");

  // register port
  cfg_store_a: assert property (cfg_wr |=> r.interval == ioch_len($past(reg_wdata))
                                && r.irq_en == $past(reg_wdata[IOCH_EN_BIT])
                                && r.pol == $past(reg_wdata[IOCH_POL_BIT])
                                && r.buf_type == $past(reg_wdata[IOCH_TYPE_BIT]))
    else $error("configuration write not stored");
  cfg_hold_a: assert property (!cfg_wr |=> $stable(r.interval) && $stable(r.irq_en)
                               && $stable(r.pol) && $stable(r.buf_type))
    else $error("configuration changed without a write");
  read_cfg_a: assert property (cfg_rd |=> reg_rdata[31:24] == $past(r.interval)
                               && reg_rdata[8] == $past(r.irq_en)
                               && reg_rdata[4] == $past(r.pol)
                               && reg_rdata[0] == $past(r.buf_type))
    else $error("configuration read back wrong");
  read_idle_a: assert property (!cfg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not cleared between reads");
  reserved_zero_a: assert property (cfg_rd |=> reg_rdata[23:15] == 9'h000
                                    && reg_rdata[11:9] == 3'h0 && reg_rdata[7:5] == 3'h0
                                    && reg_rdata[3:1] == 3'h0)
    else $error("reserved bits read non-zero");
  status_read_a: assert property (cfg_rd
                                  |=> reg_rdata[13] == $past(hold.active)
                                  && reg_rdata[12] == $past(irq_int)
                                  && reg_rdata[14] == 1'b0)
    else $error("status bits read wrong");
  int_ungated_a: assert property (cfg_rd && !r.irq_en
                                  && |(source_status & source_enable) |=> reg_rdata[12])
    else $error("combined request gated by enable");

  // pin level
  push_pull_a: assert property (r.buf_type |-> r.pin_oe
                                && r.pin_o == (r.pol ? r.asserted : !r.asserted))
    else $error("push-pull level wrong");
  open_drain_a: assert property (!r.buf_type |-> r.pin_oe == r.asserted && !r.pin_o)
    else $error("open-drain drive wrong");
  holdoff_pin_a: assert property (hold.active && !power_event
                                  |=> (r.buf_type ? r.pin_o == !r.pol : !r.pin_oe))
    else $error("pin driven during hold-off");
  disabled_pin_a: assert property (!r.irq_en && !cfg_wr
                                   |=> (r.buf_type ? r.pin_o == !r.pol : !r.pin_oe))
    else $error("pin driven while output disabled");

  pin_up_c: cover property (r.irq_en && $rose(r.asserted));
  expire_c: cover property ($fell(hold.active) && irq_int && r.irq_en ##1 r.asserted);
  restart_c: cover property (cfg_wr && reg_wdata[14] && hold.active);
  power_hold_c: cover property (hold.active && power_event && r.asserted);
  zero_stop_c: cover property (cfg_wr && ioch_len(reg_wdata) == 8'h00 && hold.active);

endmodule : ioch_top

// file: sim/ioch_host_model.sv
`timescale 1ns/1ps
module ioch_host_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic act_high,
  output logic      line,
  output logic      seen
);
  // board pull-up holds the released line high, so open-drain only pulls low
  assign line = pin_oe ? pin_o : 1'b1;
  // host input is set up for the polarity it expects on the line
  assign seen = act_high ? line : !line;
endmodule : ioch_host_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import ioch_pkg::*;
  logic        clock, srst, reg_wr, reg_rd, pwr, ah, pin_o, pin_oe, line, seen;
  logic [7:0]  addr;
  logic [31:0] wd, rdata, st, en, rv;
  int          err_count, checked, n, i;
  time         t0;

  ioch_top i_dut (.clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata), .source_status(st),
    .source_enable(en), .power_event(pwr), .irq_pin_o(pin_o), .irq_pin_oe(pin_oe));
  ioch_host_model i_host (.pin_o(pin_o), .pin_oe(pin_oe), .act_high(ah), .line(line),
    .seen(seen));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  function logic [31:0] cfg(input logic [7:0] l, input logic e, p, t, r);
    cfg = {l, 24'h000000};
    cfg[IOCH_RESTART_BIT] = r;
    cfg[IOCH_EN_BIT] = e;
    cfg[IOCH_POL_BIT] = p;
    cfg[IOCH_TYPE_BIT] = t;
  endfunction : cfg

  task wr(input logic [31:0] d);
    @(posedge clock);
    addr <= 8'h54;
    wd <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  task cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // bounded wait for the line to be pulled low again; returns cycles since t0
  task wait_low(input int lim);
    i = 0;
    while (line !== 1'b0 && i < lim) begin
      @(posedge clock);
      #1;
      i++;
    end
    n = int'(($time - t0) / 20);
    if (i >= lim) begin
      err_count++;
      $display("[FAIL] %0t line never reasserted", $time);
      report_and_stop;
    end
  endtask : wait_low

  initial begin
    {reg_wr, reg_rd, pwr, ah, addr, wd, st, en} = '0;
    srst = 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    rd(8'h54);
    chk(rv === 32'h00000000, "reset value");
    rd(8'h58);
    chk(rv === 32'h00000000, "unmapped read not zero");
    wr(cfg(8'hA5, 1'b0, 1'b1, 1'b1, 1'b1));
    rd(8'h54);
    chk(rv === 32'hA5002011, "config readback");
    $display("test registers done");
    st[3] <= 1'b1;
    en[3] <= 1'b1;
    // every polarity and buffer pairing; open-drain ignores polarity
    for (int k = 0; k < 4; k++) begin
      ah <= (k == 3);
      wr(cfg(8'h00, 1'b1, k[1], k[0], 1'b0));
      cyc(2);
      chk(line === (k == 3) && pin_oe === 1'b1 && seen === 1'b1, "pin level");
    end
    wr(cfg(8'h00, 1'b0, 1'b0, 1'b0, 1'b0));
    cyc(2);
    rd(8'h54);
    chk(line === 1'b1 && rv[12] === 1'b1, "disable vs internal line");
    en[3] <= 1'b0;
    rd(8'h54);
    rd(8'h54);
    chk(rv[12] === 1'b0, "masked source still flagged");
    en[3] <= 1'b1;
    $display("test pin modes done");
    wr(cfg(8'h01, 1'b1, 1'b0, 1'b0, 1'b0));
    cyc(2);
    chk(line === 1'b0, "pin not asserted");
    @(posedge clock);
    st <= '0;  // host acknowledges the source
    t0 = $time;
    cyc(3);
    st[3] <= 1'b1;
    rd(8'h54);
    chk(rv[13] === 1'b1 && rv[12] === 1'b1 && line === 1'b1, "hold-off start");
    pwr <= 1'b1;
    cyc(2);
    chk(line === 1'b0, "power event held off");
    pwr <= 1'b0;
    cyc(2);
    wait_low(700);
    chk(n >= 498 && n <= 510, "one-step interval length");
    $display("test hold-off done");
    @(posedge clock);
    st <= '0;
    cyc(3);
    st[3] <= 1'b1;
    wr(cfg(8'h00, 1'b1, 1'b0, 1'b0, 1'b0));
    cyc(2);
    rd(8'h54);
    chk(line === 1'b0 && rv[13] === 1'b0, "zero length release");
    wr(cfg(8'h02, 1'b1, 1'b0, 1'b0, 1'b1));
    cyc(600);
    chk(line === 1'b1, "two-step interval ended early");
    wr(cfg(8'h02, 1'b1, 1'b0, 1'b0, 1'b1));
    t0 = $time;
    wait_low(1200);
    chk(n >= 995 && n <= 1008, "restart length");
    $display("test restart done");
    report_and_stop;
  end
endmodule : tb
